/* verilog/strap_cfg_pkg.sv */
// Purpose: constants for the reset strap capture and peripheral select block
// Assumes: straps are stable while srst is high
// Notes:   all encodings below are those of the strap pins
//
// Overview of operation
// - Sample all straps during reset, decode selections
// - PCI strap 0: host port enabled, except Ethernet strap with wide width
// - PCI off: shared pins host unless Ethernet strap with wide width, PCI-only pins tristate
// - PCI off: bank0 pins 15..9 usable as GPIO
// - PCI strap 1: host port off, PCI on
// - PCI on: Ethernet, MDIO, GPIO 15..9 disabled
// - Ethernet enable from Ethernet and PCI straps only
// - PCI on, autoinit 1: load from EEPROM
// - Autoinit 0: skip EEPROM, use defaults
// - Byte order: 0 big, 1 little endian
// - Boot mode from address pins 22:21
// - Memory clock select: input, cpu/4, cpu/6
// - PCI speed strap: 0 66 MHz, 1 33 MHz
// - Narrow host: data 15:0, upper to Ethernet if strapped, else tristate
// - Wide host: all 32 data pins used
// - PCI/Ethernet strap pair decode, 11 reserved
package strap_cfg_pkg;

    // =====================================================
    // Boot modes
    localparam logic [1:0] BOOT_NONE     = 2'h0;
    localparam logic [1:0] BOOT_HOST_PCI = 2'h1;
    localparam logic [1:0] BOOT_RSVD     = 2'h2;
    localparam logic [1:0] BOOT_EXT_MEM  = 2'h3;

    // =====================================================
    // External memory clock sources
    localparam logic [1:0] ECLK_INPUT    = 2'h0;
    localparam logic [1:0] ECLK_CPU_DIV4 = 2'h1;
    localparam logic [1:0] ECLK_CPU_DIV6 = 2'h2;
    localparam logic [1:0] ECLK_RSVD     = 2'h3;

    // =====================================================
    // PCI / Ethernet strap pair
    localparam logic [1:0] SEL_HOST      = 2'h0;
    localparam logic [1:0] SEL_ETH       = 2'h1;
    localparam logic [1:0] SEL_PCI       = 2'h2;
    localparam logic [1:0] SEL_RSVD      = 2'h3;

    // =====================================================
    // Single-bit encodings
    localparam logic       ENDIAN_BIG    = 1'h0;
    localparam logic       ENDIAN_LITTLE = 1'h1;
    localparam logic       PCI_SPEED_66  = 1'h0;
    localparam logic       PCI_SPEED_33  = 1'h1;
    localparam logic       WIDTH_NARROW  = 1'h0;
    localparam logic       WIDTH_WIDE    = 1'h1;

    // =====================================================
    // Documented strap defaults; the capture registers are never reset to these values
    localparam logic       RST_BYTE_ORDER = ENDIAN_LITTLE;
    localparam logic [1:0] RST_BOOT       = BOOT_NONE;
    localparam logic [1:0] RST_ECLK       = ECLK_INPUT;
    localparam logic       RST_AUTOINIT   = 1'h0;
    localparam logic       RST_PCI_SPEED  = PCI_SPEED_66;
    localparam logic       RST_WIDTH      = WIDTH_NARROW;
    localparam logic       RST_PCI_SEL    = 1'h0;
    localparam logic       RST_ETH_SEL    = 1'h0;
    localparam logic       RST_GP0_PIN0   = 1'h0;

endpackage

/* verilog/reset_strap_peripheral_select.sv */
// Purpose: capture strap pins during reset and decode pin sharing and modes
// Assumes: straps are board resistors, asynchronous to mclk
// Notes:   selections stay frozen from reset release to the next reset
`timescale 1ns/10ps

module reset_strap_peripheral_select (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       pci_select_strap,
    input  wire logic       pci_eeprom_autoinit_pin,
    input  wire logic       host_width_strap,
    input  wire logic       ethernet_select_strap,
    input  wire logic       byte_order_strap,
    input  wire logic [1:0] ext_mem_addr_pins,
    input  wire logic [1:0] ext_mem_clock_select,
    input  wire logic       pci_speed_strap,
    input  wire logic       gp0_pin0_strap,
    output logic            byte_order_mode,
    output logic [1:0]      boot_mode,
    output logic [1:0]      ext_mem_clock_source,
    output logic            pci_enable,
    output logic            pci_eeprom_autoinit,
    output logic            pci_speed_33,
    output logic            host_port_enable,
    output logic            host_port_width,
    output logic            host_data_low_enable,
    output logic            host_data_high_enable,
    output logic            host_data_high_eth,
    output logic            pci_only_pins_oe_n,
    output logic            eth_mdio_enable,
    output logic            gpio_high_available,
    output logic            strap_reserved,
    output logic            strap_invalid
);

    // =====================================================
    // Two-stage synchronisers on all strap pins
    localparam int SW = 11;

    logic [SW-1:0] pins;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic [SW-1:0] sync1_nxt;
    logic [SW-1:0] sync2_nxt;

    assign pins = {pci_select_strap, pci_eeprom_autoinit_pin, host_width_strap, ethernet_select_strap,
                   byte_order_strap, ext_mem_addr_pins, ext_mem_clock_select, pci_speed_strap,
                   gp0_pin0_strap};

    always_comb begin
        sync1_nxt = pins;
        sync2_nxt = sync1_r;
    end

    always_ff @(posedge mclk) begin
        sync1_r <= sync1_nxt;
        sync2_r <= sync2_nxt;
    end

    // =====================================================
    // Capture while reset is high, freeze afterwards
    logic       pci_sel_r,   pci_sel_nxt;
    logic       autoinit_r,  autoinit_nxt;
    logic       width_r,     width_nxt;
    logic       eth_sel_r,   eth_sel_nxt;
    logic       order_r,     order_nxt;
    logic [1:0] boot_r,      boot_nxt;
    logic [1:0] eclk_r,      eclk_nxt;
    logic       speed_r,     speed_nxt;
    logic       gp0_r,       gp0_nxt;

    always_comb begin
        pci_sel_nxt  = pci_sel_r;
        autoinit_nxt = autoinit_r;
        width_nxt    = width_r;
        eth_sel_nxt  = eth_sel_r;
        order_nxt    = order_r;
        boot_nxt     = boot_r;
        eclk_nxt     = eclk_r;
        speed_nxt    = speed_r;
        gp0_nxt      = gp0_r;
        // Sampling the synchronised copy; last sample before release wins
        if (srst) begin
            pci_sel_nxt  = sync2_r[10];
            autoinit_nxt = sync2_r[9];
            width_nxt    = sync2_r[8];
            eth_sel_nxt  = sync2_r[7];
            order_nxt    = sync2_r[6];
            boot_nxt     = sync2_r[5:4];
            eclk_nxt     = sync2_r[3:2];
            speed_nxt    = sync2_r[1];
            gp0_nxt      = sync2_r[0];
        end
    end

    // Not reset to constants: the capture itself is the reset behaviour
    always_ff @(posedge mclk) begin
        pci_sel_r  <= pci_sel_nxt;
        autoinit_r <= autoinit_nxt;
        width_r    <= width_nxt;
        eth_sel_r  <= eth_sel_nxt;
        order_r    <= order_nxt;
        boot_r     <= boot_nxt;
        eclk_r     <= eclk_nxt;
        speed_r    <= speed_nxt;
        gp0_r      <= gp0_nxt;
    end

    // =====================================================
    // Decode into registered selections
    logic [1:0] pair;
    logic       pci_on;
    logic       host_on;
    logic       eth_on;
    logic       pair_rsvd;

    assign pair = {pci_sel_r, eth_sel_r};

    // Pin-sharing decision from the strap pair and the width strap
    always_comb begin
        pci_on    = 1'b0;
        host_on   = 1'b0;
        eth_on    = 1'b0;
        pair_rsvd = 1'b0;
        case (pair)
            strap_cfg_pkg::SEL_HOST: begin
                host_on = 1'b1;
            end
            strap_cfg_pkg::SEL_ETH: begin
                eth_on  = 1'b1;
                host_on = (width_r == strap_cfg_pkg::WIDTH_NARROW);
            end
            strap_cfg_pkg::SEL_PCI: begin
                pci_on = 1'b1;
            end
            default: begin
                // Reserved pair: PCI strap still wins, nothing else enabled
                pci_on    = 1'b1;
                pair_rsvd = 1'b1;
            end
        endcase
    end

    // =====================================================
    // Output registers, one per selection
    logic       byte_order_mode_r,       byte_order_mode_nxt;
    logic [1:0] boot_mode_r,             boot_mode_nxt;
    logic [1:0] ext_mem_clock_source_r,  ext_mem_clock_source_nxt;
    logic       pci_enable_r,            pci_enable_nxt;
    logic       pci_eeprom_autoinit_r,   pci_eeprom_autoinit_nxt;
    logic       pci_speed_33_r,          pci_speed_33_nxt;
    logic       host_port_enable_r,      host_port_enable_nxt;
    logic       host_port_width_r,       host_port_width_nxt;
    logic       host_data_low_enable_r,  host_data_low_enable_nxt;
    logic       host_data_high_enable_r, host_data_high_enable_nxt;
    logic       host_data_high_eth_r,    host_data_high_eth_nxt;
    logic       pci_only_pins_oe_n_r,    pci_only_pins_oe_n_nxt;
    logic       eth_mdio_enable_r,       eth_mdio_enable_nxt;
    logic       gpio_high_available_r,   gpio_high_available_nxt;
    logic       strap_reserved_r,        strap_reserved_nxt;
    logic       strap_invalid_r,         strap_invalid_nxt;

    always_comb begin
        byte_order_mode_nxt       = order_r;
        boot_mode_nxt             = boot_r;
        ext_mem_clock_source_nxt  = eclk_r;
        pci_enable_nxt            = pci_on;
        pci_eeprom_autoinit_nxt   = pci_on & autoinit_r;
        pci_speed_33_nxt          = pci_on & (speed_r == strap_cfg_pkg::PCI_SPEED_33);
        host_port_enable_nxt      = host_on;
        host_port_width_nxt       = host_on & (width_r == strap_cfg_pkg::WIDTH_WIDE);
        host_data_low_enable_nxt  = host_on;
        host_data_high_enable_nxt = host_on & (width_r == strap_cfg_pkg::WIDTH_WIDE);
        host_data_high_eth_nxt    = ~pci_on & eth_on;
        // Active low: PCI-only pins float whenever PCI is off
        pci_only_pins_oe_n_nxt    = ~pci_on;
        eth_mdio_enable_nxt       = ~pci_on & eth_on;
        gpio_high_available_nxt   = ~pci_on;
        strap_reserved_nxt        = pair_rsvd || (boot_r == strap_cfg_pkg::BOOT_RSVD)
                                    || (eclk_r == strap_cfg_pkg::ECLK_RSVD);
        strap_invalid_nxt         = gp0_r;
        // Everything reads as off while reset is high, so no peripheral
        // sees a half-captured selection
        if (srst) begin
            byte_order_mode_nxt       = 1'b0;
            boot_mode_nxt             = 2'h0;
            ext_mem_clock_source_nxt  = 2'h0;
            pci_enable_nxt            = 1'b0;
            pci_eeprom_autoinit_nxt   = 1'b0;
            pci_speed_33_nxt          = 1'b0;
            host_port_enable_nxt      = 1'b0;
            host_port_width_nxt       = 1'b0;
            host_data_low_enable_nxt  = 1'b0;
            host_data_high_enable_nxt = 1'b0;
            host_data_high_eth_nxt    = 1'b0;
            pci_only_pins_oe_n_nxt    = 1'b1;
            eth_mdio_enable_nxt       = 1'b0;
            gpio_high_available_nxt   = 1'b0;
            strap_reserved_nxt        = 1'b0;
            strap_invalid_nxt         = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        byte_order_mode_r       <= byte_order_mode_nxt;
        boot_mode_r             <= boot_mode_nxt;
        ext_mem_clock_source_r  <= ext_mem_clock_source_nxt;
        pci_enable_r            <= pci_enable_nxt;
        pci_eeprom_autoinit_r   <= pci_eeprom_autoinit_nxt;
        pci_speed_33_r          <= pci_speed_33_nxt;
        host_port_enable_r      <= host_port_enable_nxt;
        host_port_width_r       <= host_port_width_nxt;
        host_data_low_enable_r  <= host_data_low_enable_nxt;
        host_data_high_enable_r <= host_data_high_enable_nxt;
        host_data_high_eth_r    <= host_data_high_eth_nxt;
        pci_only_pins_oe_n_r    <= pci_only_pins_oe_n_nxt;
        eth_mdio_enable_r       <= eth_mdio_enable_nxt;
        gpio_high_available_r   <= gpio_high_available_nxt;
        strap_reserved_r        <= strap_reserved_nxt;
        strap_invalid_r         <= strap_invalid_nxt;
    end

    assign byte_order_mode       = byte_order_mode_r;
    assign boot_mode             = boot_mode_r;
    assign ext_mem_clock_source  = ext_mem_clock_source_r;
    assign pci_enable            = pci_enable_r;
    assign pci_eeprom_autoinit   = pci_eeprom_autoinit_r;
    assign pci_speed_33          = pci_speed_33_r;
    assign host_port_enable      = host_port_enable_r;
    assign host_port_width       = host_port_width_r;
    assign host_data_low_enable  = host_data_low_enable_r;
    assign host_data_high_enable = host_data_high_enable_r;
    assign host_data_high_eth    = host_data_high_eth_r;
    assign pci_only_pins_oe_n    = pci_only_pins_oe_n_r;
    assign eth_mdio_enable       = eth_mdio_enable_r;
    assign gpio_high_available   = gpio_high_available_r;
    assign strap_reserved        = strap_reserved_r;
    assign strap_invalid         = strap_invalid_r;

endmodule // reset_strap_peripheral_select

/* tb/strap_sel_chk_sva.sv */
// Purpose: assertions on the decoded strap selections
// Assumes: bound to the top module, one clock domain
// Notes:   decode relations hold from the second edge after release
`timescale 1ns/10ps

module strap_sel_chk (
    input wire logic mclk,
    input wire logic srst,
    input wire logic byte_order_strap,
    input wire logic byte_order_mode,
    input wire logic pci_enable,
    input wire logic pci_eeprom_autoinit,
    input wire logic pci_speed_33,
    input wire logic host_port_enable,
    input wire logic host_data_low_enable,
    input wire logic host_data_high_enable,
    input wire logic host_data_high_eth,
    input wire logic pci_only_pins_oe_n,
    input wire logic eth_mdio_enable,
    input wire logic gpio_high_available
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    // ==============================================
    // Capture and decode
    AST_CAPTURE: assert property ($fell(srst) && $stable(byte_order_strap)
        && $past(byte_order_strap, 2) == byte_order_strap && $past(byte_order_strap, 3) == byte_order_strap
        |=> byte_order_mode == $past(byte_order_strap)) else $error("byte order not captured");
    AST_PINS_OFF: assert property (!$past(srst) |-> pci_only_pins_oe_n == !pci_enable)
        else $error("pci-only pins not tied to pci select");
    AST_PCI_EXCL: assert property (pci_enable |-> !host_port_enable && !eth_mdio_enable
        && !gpio_high_available && !host_data_low_enable) else $error("pci shares pins with others");
    AST_HOST_ON: assert property (!$past(srst) && !pci_enable
        |-> gpio_high_available && (host_port_enable || eth_mdio_enable)) else $error("pci off but no host");
    AST_AUTOINIT: assert property (pci_eeprom_autoinit |-> pci_enable)
        else $error("autoinit without pci");
    AST_SPEED: assert property (pci_speed_33 |-> pci_enable)
        else $error("pci speed without pci");
    AST_WIDE: assert property (host_data_high_enable |-> host_data_low_enable && !host_data_high_eth)
        else $error("wide host pins conflict");
    AST_ETH: assert property (eth_mdio_enable |-> host_data_high_eth && !host_data_high_enable)
        else $error("ethernet pins conflict");
    AST_HOLD: assert property (!$past(srst) |=> $stable({pci_enable, host_port_enable, eth_mdio_enable,
        byte_order_mode, gpio_high_available})) else $error("selection moved after release");
endmodule // strap_sel_chk

bind reset_strap_peripheral_select strap_sel_chk strap_sel_chk_i (.mclk(mclk), .srst(srst),
    .byte_order_strap(byte_order_strap), .byte_order_mode(byte_order_mode), .pci_enable(pci_enable),
    .pci_eeprom_autoinit(pci_eeprom_autoinit), .pci_speed_33(pci_speed_33), .host_port_enable(host_port_enable),
    .host_data_low_enable(host_data_low_enable), .host_data_high_enable(host_data_high_enable),
    .host_data_high_eth(host_data_high_eth), .pci_only_pins_oe_n(pci_only_pins_oe_n),
    .eth_mdio_enable(eth_mdio_enable), .gpio_high_available(gpio_high_available));

/* tb/strap_board.sv */
// Purpose: board strap resistors seen by the strap block
// Assumes: word bits {gp0, speed, clk[1:0], boot[1:0], byte, eth, width, autoinit, pci}
// Notes:   after release with wiggle high the pins are reused and toggle every cycle
`timescale 1ns/10ps

module strap_board (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        wiggle,
    input  wire logic [10:0] word,
    output logic      [10:0] pins
);
    logic [10:0] flip_r = 11'h555;

    always_ff @(posedge mclk) begin
        flip_r <= ~flip_r;
    end

    // Gp0 pin 0 follows the word; only one scenario sets it high on purpose
    // Speed pull-up fitted only together with pci select
    assign pins = (srst || !wiggle) ? {word[10], word[9] & word[0], word[8:0]} : flip_r ^ word;
endmodule // strap_board

/* tb/test_reset_strap_peripheral_select.sv */
// Purpose: self-checking bench for the strap capture block
// Assumes: straps stable for the whole reset span
// Notes:   every output is compared after each boot
`timescale 1ns/10ps

module test_reset_strap_peripheral_select;
    logic        mclk       = 1'b0;
    logic        srst       = 1'b1;
    logic        wiggle     = 1'b0;
    logic [10:0] word       = 11'h000;
    logic [10:0] pins;
    wire  [17:0] got;
    int          mismatches = 0;
    int          n_checks   = 0;

    always #50 mclk = ~mclk;

    strap_board strap_board_i (.mclk(mclk), .srst(srst), .wiggle(wiggle), .word(word), .pins(pins));

    reset_strap_peripheral_select reset_strap_peripheral_select_i (.mclk(mclk), .srst(srst),
        .pci_select_strap(pins[0]), .pci_eeprom_autoinit_pin(pins[1]), .host_width_strap(pins[2]),
        .ethernet_select_strap(pins[3]), .byte_order_strap(pins[4]), .ext_mem_addr_pins(pins[6:5]),
        .ext_mem_clock_select(pins[8:7]), .pci_speed_strap(pins[9]), .gp0_pin0_strap(pins[10]),
        .byte_order_mode(got[16]), .boot_mode(got[15:14]), .ext_mem_clock_source(got[13:12]),
        .pci_enable(got[11]), .pci_eeprom_autoinit(got[10]), .pci_speed_33(got[9]),
        .host_port_enable(got[8]), .host_port_width(got[17]), .host_data_low_enable(got[7]),
        .host_data_high_enable(got[6]), .host_data_high_eth(got[5]), .pci_only_pins_oe_n(got[4]),
        .eth_mdio_enable(got[3]), .gpio_high_available(got[2]), .strap_reserved(got[1]), .strap_invalid(got[0]));

    // ==============================================
    // Shared tasks
    function automatic logic [17:0] expect_of(logic [10:0] w);
        logic p, wd, e, h;
        p = w[0];
        wd = w[2];
        e = w[3];
        h = !p && !(e && wd);
        return {!p & !e & wd, w[4], w[6:5], w[8:7], p, p & w[1], p & w[9], h, h,
                !p & !e & wd, !p & e, !p, !p & e, !p,
                (p & e) | (w[6:5] == 2'h2) | (w[8:7] == 2'h3), w[10]};
    endfunction

    task automatic check(logic [17:0] e);
        n_checks++;
        if (got !== e) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, e);
        end
    endtask

    task automatic boot_with(logic [10:0] w);
        @(posedge mclk);
        srst <= 1'b1;
        word <= w;
        repeat (6) @(posedge mclk);
        #1 check(18'h00010);
        @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1;
    endtask

    // ==============================================
    // Scenarios
    task automatic sc_selection();
        logic [10:0] w;
        for (int i = 0; i < 16; i++) begin
            w = {1'b0, i[2], 4'h0, 1'b1, i[3:0]};
            boot_with(w);
            check(expect_of(w));
        end
    endtask

    task automatic sc_modes();
        logic [10:0] w;
        for (int i = 0; i < 16; i++) begin
            w = {i == 15, 1'b1, i[3:2], i[1:0], i[0], 4'h1};
            boot_with(w);
            check(expect_of(w));
        end
    endtask

    task automatic sc_hold();
        boot_with(11'h01c);
        @(posedge mclk) wiggle <= 1'b1;
        repeat (20) @(posedge mclk);
        #1 check(expect_of(11'h01c));
        @(posedge mclk) wiggle <= 1'b0;
        boot_with(11'h013);
        check(expect_of(11'h013));
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Run takes about 330 cycles; margin is generous
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge mclk);
        sc_selection();
        sc_modes();
        sc_hold();
        report_and_stop();
    end
endmodule // test_reset_strap_peripheral_select
